/* common/swe_pkg.sv */
// constants for the stop wake event logic
package swe_pkg;
	// register indices; the byte address on the bus is four times the index
	localparam logic [11:0] IDX_GATE_WAKE_CTRL  = 12'hf0d;
	localparam logic [11:0] IDX_PT3_PIN_WAKE_SEL = 12'hf0e;
	localparam logic [11:0] IDX_WAKE_STATUS     = 12'hf0a;
	localparam logic [11:0] IDX_PORT3_DATA      = 12'hf03;
	localparam logic [11:0] IDX_WAKE_EVENTS     = 12'hf10;
	localparam logic [11:0] IDX_WAKE_MASK       = 12'hf11;
	localparam logic [11:0] IDX_PORT_DIR        = 12'hf12;
	localparam logic [11:0] IDX_P2_PIN_WAKE_SEL = 12'hf13;
	localparam int          ADDR_W              = 14;
	// field positions
	localparam int          GWC_LEVEL_BIT       = 6;
	localparam int          GWC_SRC_LSB         = 2;
	localparam int          WST_IRQ_EN_BIT      = 4;
	localparam int          WST_REF_LSB         = 2;
	// gate source codes
	localparam logic [2:0]  GSRC_NONE           = 3'h0;
	localparam logic [2:0]  GSRC_NAND_P2_LO     = 3'h1;
	localparam logic [2:0]  GSRC_NAND_P2_ALL    = 3'h2;
	localparam logic [2:0]  GSRC_NOR_PT3        = 3'h3;
	localparam logic [2:0]  GSRC_NAND_PT3       = 3'h4;
	localparam logic [2:0]  GSRC_NOR_PT3_P0     = 3'h5;
	localparam logic [2:0]  GSRC_NAND_PT3_P0    = 3'h6;
	// reference status codes
	localparam logic [1:0]  REF_NONE            = 2'h0;
	localparam logic [1:0]  REF_READ            = 2'h1;
	localparam logic [1:0]  REF_WRITE           = 2'h2;
	// reset values
	localparam logic [7:0]  RST_BYTE            = 8'h00;
	// axi responses
	localparam logic [1:0]  RESP_OKAY           = 2'h0;
	localparam logic [1:0]  RESP_SLVERR         = 2'h2;
endpackage : swe_pkg

/* hw/swe_sync.sv */
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none
module swe_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// async in, filtered out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	// first stage is read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit changes only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					out_q[i] <= 1'b0;
				end else if (s2_q[i] == s3_q[i]) begin
					out_q[i] <= s3_q[i];
				end
			end
		end
	endgenerate

	assign sync_out = out_q;
endmodule : swe_sync
`default_nettype wire

/* hw/swe_wake_logic.sv */
// stop wake event logic with axi4-lite register slave
//
// Behaviour
// - gate source field picks one of seven modes
// - wake when gate output equals level bit
// - gate ignores port3 output pins and per-pin sources
// - gate modes: nand/nor over port2/3/0 pins
// - fields clear at reset, kept over recovery
// - port3 select bits make pins sources
// - without reference, selected pin wakes at zero
// - port3 data access captures pin reference
// - wake when pin differs from captured reference
// - status reads 01 after read, 10 after write
// - writing 00 restores zero-level default
// - upper port3 select bits ignore writes
// - port3 pin wake ends stop state
// - irq enable bit raises interrupt per event
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module swe_wake_logic (
	// clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// axi4-lite write address
	input  wire logic [swe_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// axi4-lite read address
	input  wire logic [swe_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// port pins (asynchronous)
	input  wire logic [7:0]                 port0_pins,
	input  wire logic [7:0]                 port2_pins,
	input  wire logic [3:0]                 port3_pins,
	// wake outputs
	output logic                            wake_request,
	output logic                            irq_line_one,
	output logic                            wake_irq
);
	import swe_pkg::*;

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic [2:0]  gsrc_q;
	logic        glevel_q;
	logic [3:0]  p3sel_q;
	logic [7:0]  p2sel_q;
	logic [1:0]  p3ref_st_q;
	logic        irq_en_q;
	logic [3:0]  p3ref_q;
	logic [7:0]  dir0_q;
	logic [7:0]  dir2_q;
	logic [3:0]  dir3_q;
	logic [3:0]  p3out_q;
	logic [2:0]  evt_q;
	logic [2:0]  mask_q;
	logic        wake_q;
	logic        irq_one_q;
	logic        irq_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_have_q;
	logic        w_have_q;

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	logic [19:0] pins_s;
	swe_sync #(.W(20)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({port3_pins, port2_pins, port0_pins}),
		.sync_out (pins_s)
	);
	wire [7:0] p0 = pins_s[7:0];
	wire [7:0] p2 = pins_s[15:8];
	wire [3:0] pt3 = pins_s[19:16];

	// -------------------------------------------------------------
	// gate event logic
	// -------------------------------------------------------------
	// excluded pins read as one for nand terms, zero for nor terms
	wire [7:0] p2_ok = ~dir2_q & ~p2sel_q;
	wire [3:0] pt3_ok = ~dir3_q & ~p3sel_q;
	wire [7:0] p0_ok = ~dir0_q;
	wire [7:0] p2_and = p2 | ~p2_ok;
	wire [3:0] pt3_and = pt3 | ~pt3_ok;
	wire [7:0] p0_and = p0 | ~p0_ok;
	wire [3:0] pt3_or  = pt3 & pt3_ok;
	wire [7:0] p0_or  = p0 & p0_ok;
	wire nand_p2_lo  = ~&p2_and[3:0];
	wire nand_p2_all = ~&p2_and;
	wire nor_pt3     = ~|pt3_or[3:1];
	wire nand_pt3    = ~&pt3_and[3:1];
	wire nor_pt3_p0  = ~(|pt3_or[3:1] | p0_or[0] | p0_or[7]);
	wire nand_pt3_p0 = ~(&pt3_and[3:1] & p0_and[0] & p0_and[7]);
	logic gate_out;
	logic gate_act;
	// code 111 is undefined here and treated like 000
	always_comb begin
		gate_out = 1'b0;
		gate_act = 1'b1;
		unique case (gsrc_q)
			GSRC_NAND_P2_LO:  gate_out = nand_p2_lo;
			GSRC_NAND_P2_ALL: gate_out = nand_p2_all;
			GSRC_NOR_PT3:     gate_out = nor_pt3;
			GSRC_NAND_PT3:    gate_out = nand_pt3;
			GSRC_NOR_PT3_P0:  gate_out = nor_pt3_p0;
			GSRC_NAND_PT3_P0: gate_out = nand_pt3_p0;
			default:          gate_act = 1'b0;
		endcase
	end
	wire gate_evt = gate_act & (gate_out == glevel_q);

	// -------------------------------------------------------------
	// per-pin port3 events
	// -------------------------------------------------------------
	// with no reference the compare value is all ones, so a selected pin wakes while low
	wire [3:0] pt3_cmp = (p3ref_st_q == REF_NONE) ? 4'hf : p3ref_q;
	wire [3:0] pin_evt = p3sel_q & (pt3 ^ pt3_cmp);
	wire pin_any = |pin_evt;
	wire wake_d  = gate_evt | pin_any;

	// -------------------------------------------------------------
	// axi4-lite slave
	// -------------------------------------------------------------
	wire aw_take = s_axi_awvalid & awready_q;
	wire w_take  = s_axi_wvalid & wready_q;
	wire wr_go   = aw_have_q & w_have_q & ~bvalid_q;
	wire [11:0] wr_idx = awaddr_q[ADDR_W-1:2];
	wire [11:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
	wire wr_en   = wr_go & wstrb_q[0];
	wire rd_go   = s_axi_arvalid & arready_q;
	wire [7:0] wb = wdata_q[7:0];
	wire w_gwc  = wr_en & (wr_idx == IDX_GATE_WAKE_CTRL);
	wire w_p3s  = wr_en & (wr_idx == IDX_PT3_PIN_WAKE_SEL);
	wire w_wst  = wr_en & (wr_idx == IDX_WAKE_STATUS);
	wire w_p3d  = wr_en & (wr_idx == IDX_PORT3_DATA);
	wire w_msk  = wr_en & (wr_idx == IDX_WAKE_MASK);
	wire w_dir  = wr_en & (wr_idx == IDX_PORT_DIR);
	wire w_p2s  = wr_en & (wr_idx == IDX_P2_PIN_WAKE_SEL);
	wire wr_map = (wr_idx == IDX_GATE_WAKE_CTRL) | (wr_idx == IDX_PT3_PIN_WAKE_SEL)
		| (wr_idx == IDX_WAKE_STATUS) | (wr_idx == IDX_PORT3_DATA) | (wr_idx == IDX_WAKE_EVENTS)
		| (wr_idx == IDX_WAKE_MASK) | (wr_idx == IDX_PORT_DIR) | (wr_idx == IDX_P2_PIN_WAKE_SEL);
	wire r_p3d  = rd_go & (rd_idx == IDX_PORT3_DATA);
	wire r_evt  = rd_go & (rd_idx == IDX_WAKE_EVENTS);
	// port3 data reads return pin state on inputs, latch on outputs
	wire [3:0] pt3_rd = (pt3 & ~dir3_q) | (p3out_q & dir3_q);
	logic [7:0] rd_byte;
	logic       rd_ok;
	always_comb begin
		rd_byte = RST_BYTE;
		rd_ok   = 1'b1;
		case (rd_idx)
			IDX_WAKE_STATUS:     rd_byte = {3'h0, irq_en_q, p3ref_st_q, 2'h0};
			IDX_PORT3_DATA:      rd_byte = {4'h0, pt3_rd};
			IDX_WAKE_EVENTS:     rd_byte = {5'h0, evt_q};
			IDX_WAKE_MASK:       rd_byte = {5'h0, mask_q};
			IDX_PORT_DIR:        rd_byte = {dir3_q, 4'h0};
			IDX_GATE_WAKE_CTRL:  rd_byte = RST_BYTE; // write-only
			IDX_PT3_PIN_WAKE_SEL: rd_byte = RST_BYTE; // write-only
			IDX_P2_PIN_WAKE_SEL: rd_byte = p2sel_q;
			default:             rd_ok   = 1'b0;
		endcase
	end

	// handshake state: one write and one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_q  <= s_axi_awaddr;
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (w_take) begin
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q & s_axi_bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// read channel, data registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else if (rd_go) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= {24'h0, rd_byte};
			rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q & s_axi_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// -------------------------------------------------------------
	// configuration registers (no stop-recovery reset path exists)
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gsrc_q   <= GSRC_NONE;
			glevel_q <= 1'b0;
			p3sel_q  <= 4'h0;
			p2sel_q  <= RST_BYTE;
			irq_en_q <= 1'b0;
			mask_q   <= 3'h0;
			dir0_q   <= RST_BYTE;
			dir2_q   <= RST_BYTE;
			dir3_q   <= 4'h0;
			p3out_q  <= 4'h0;
		end else begin
			if (w_gwc) begin
				// reserved bits 7,5,1,0 are simply dropped
				gsrc_q   <= wb[GWC_SRC_LSB +: 3];
				glevel_q <= wb[GWC_LEVEL_BIT];
			end
			if (w_p3s) begin
				p3sel_q <= wb[3:0];
			end
			if (w_wst) begin
				irq_en_q <= wb[WST_IRQ_EN_BIT];
			end
			if (w_msk) begin
				mask_q <= wb[2:0];
			end
			if (w_dir) begin
				dir3_q <= wb[7:4];
			end
			if (w_p2s) begin
				p2sel_q <= wb;
			end
			if (w_p3d) begin
				p3out_q <= wb[3:0];
			end
		end
	end

	// -------------------------------------------------------------
	// port3 reference capture and status field
	// -------------------------------------------------------------
	// a data access in the same cycle as a status write wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p3ref_q    <= 4'h0;
			p3ref_st_q <= REF_NONE;
		end else if (w_p3d) begin
			p3ref_q    <= wb[3:0];
			p3ref_st_q <= (|p3sel_q) ? REF_WRITE : p3ref_st_q;
		end else if (r_p3d) begin
			p3ref_q    <= pt3_rd;
			p3ref_st_q <= (|p3sel_q) ? REF_READ : p3ref_st_q;
		end else if (w_wst) begin
			p3ref_st_q <= wb[WST_REF_LSB +: 2];
		end
	end

	// -------------------------------------------------------------
	// event status, wake request and interrupts
	// -------------------------------------------------------------
	// sticky events: bit0 gate, bit1 port3 pin, bit2 any; set beats read-clear
	wire [2:0] evt_now = {wake_d, pin_any, gate_evt};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_q  <= 3'h0;
			wake_q <= 1'b0;
			irq_one_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			evt_q  <= (r_evt ? 3'h0 : evt_q) | evt_now;
			wake_q <= wake_d;
			irq_one_q <= wake_d & irq_en_q;
			irq_q  <= |(((r_evt ? 3'h0 : evt_q) | evt_now) & mask_q);
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign wake_request  = wake_q;
	assign irq_line_one  = irq_one_q;
	assign wake_irq      = irq_q;
endmodule : swe_wake_logic
`default_nettype wire

/* tb/swe_wake_logic_assertions.sv */
// port-level checker for the stop wake event logic
`timescale 1ns/1ps
`default_nettype none
module swe_wake_logic_assertions
	import swe_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	// pins and wake outputs
	input wire logic [7:0]  port0_pins,
	input wire logic [7:0]  port2_pins,
	input wire logic [3:0]  port3_pins,
	input wire logic        wake_request,
	input wire logic        irq_line_one,
	input wire logic        wake_irq
);
	// ----------------
	// quiet counter
	// ----------------
	logic [3:0] quiet_q;
	// counts cycles with no bus request and no pin movement; saturates
	always_ff @(posedge aclk) begin
		if (!aresetn || s_axi_awvalid || s_axi_arvalid || !$stable({port0_pins, port2_pins, port3_pins}))
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end
	// ----------------
	// properties
	// ----------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
	// both halves are held one edge after the take, and the response rises at the edge after that
	property p_wr_answer; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_bwait; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_bwait: assert property (p_bwait) else $error("write taken while response pending");
	property p_rwait; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rwait: assert property (p_rwait) else $error("read taken while data pending");
	property p_err; s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("error read carries data");
	property p_irq; irq_line_one |-> wake_request; endproperty
	a_irq: assert property (p_irq) else $error("interrupt without wake");
	property p_rst; $rose(aresetn) |-> (!wake_request && !irq_line_one && !wake_irq) [*3]; endproperty
	a_rst: assert property (p_rst) else $error("wake output after reset");
	property p_quiet; quiet_q >= 4'h8 |-> $stable({wake_request, irq_line_one, wake_irq}); endproperty
	a_quiet: assert property (p_quiet) else $error("wake output moved without cause");
endmodule : swe_wake_logic_assertions
bind swe_wake_logic swe_wake_logic_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rresp, .s_axi_rdata, .port0_pins, .port2_pins, .port3_pins, .wake_request, .irq_line_one,
	.wake_irq);
`default_nettype wire

/* tb/swe_pins.sv */
// pin driver standing in for the external port inputs
`timescale 1ns/1ps
`default_nettype none
module swe_pins (
	// clock
	input  wire logic        aclk,
	// requested levels
	input  wire logic [19:0] pin_set,
	// pins seen by the block
	output logic      [7:0]  port0_pins,
	output logic      [7:0]  port2_pins,
	output logic      [3:0]  port3_pins
);
	// all pins move together just after an edge, so no half-changed pattern is seen
	initial {port0_pins, port2_pins, port3_pins} = 20'h0;
	always @(posedge aclk) begin
		{port0_pins, port2_pins, port3_pins} <= pin_set;
	end
endmodule : swe_pins
`default_nettype wire

/* tb/swe_wake_logic_test.sv */
// self-checking bench for the stop wake event logic
`timescale 1ns/1ps
`default_nettype none
module swe_wake_logic_test;
	import swe_pkg::*;
	// ----------------
	// signals and model state
	// ----------------
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv;
	logic [19:0] pv;
	logic [15:0] lf;
	logic [7:0]  p0, p2, q0, q2, p2s, dir, lat, d;
	logic [3:0]  pn3, q3, p3s, rf;
	logic [2:0]  gs, msk, stk, e;
	logic [1:0]  bresp, rresp, br, rr, mode;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, lv, en, wk, iq, wi;
	int   bad_count, n_tests, i;
	swe_pins u_pins (.aclk(aclk), .pin_set(pv), .port0_pins(q0), .port2_pins(q2), .port3_pins(q3));
	swe_wake_logic u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port0_pins(q0),
		.port2_pins(q2), .port3_pins(q3), .wake_request(wk), .irq_line_one(iq), .wake_irq(wi));
	// 200 mhz clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// ----------------
	// tasks
	// ----------------
	// ready is sampled before the edge so the release lands right after the taking edge
	task automatic wr(input logic [11:0] idx, input logic [7:0] val);
		logic a, w, b;
		@(posedge aclk);
		awaddr  <= {idx, 2'b00};
		wdata   <= {24'h0, val};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(negedge aclk);
			{a, w, b, br} = {awready, wready, bvalid, bresp};
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] idx);
		logic a, b;
		@(posedge aclk);
		araddr  <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(negedge aclk);
			{a, b, rr, rdv} = {arready, rvalid, rresp, rdata};
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
		end while (!b);
		rready <= 1'b0;
	endtask : rd
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic conclude();
		if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	// events {any, pin, gate}; excluded pins sit at the neutral level of each gate
	function automatic logic [2:0] ev();
		logic [7:0] a;
		logic [3:0] x, o;
		logic g, gt, q;
		a = p2 | p2s;
		x = pn3 | p3s | dir[7:4];
		o = pn3 & ~p3s & ~dir[7:4];
		case (gs)
			3'h1: g = ~&a[3:0];
			3'h2: g = ~&a;
			3'h3: g = ~|o[3:1];
			3'h4: g = ~&x[3:1];
			3'h5: g = ~|{o[3:1], p0[0], p0[7]};
			3'h6: g = ~&{x[3:1], p0[0], p0[7]};
			default: g = 1'b0;
		endcase
		gt = gs != 3'h0 && gs != 3'h7 && g == lv;
		q = |(p3s & (pn3 ^ (mode == REF_NONE ? 4'hf : rf)));
		return {gt | q, q, gt};
	endfunction : ev
	// ----------------
	// watchdog and main sequence
	// ----------------
	initial begin
		#200000;
		bad_count++;
		conclude();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, pv} = '0;
		{gs, lv, p3s, p2s, dir, mode, rf, en, msk, stk, lat, p0, p2, pn3} = '0;
		bad_count = 0;
		n_tests = 0;
		lf = 16'h2115; // seed 8469
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(IDX_WAKE_STATUS);
		chk(rdv, 32'h0);
		rd(12'h000);
		chk({rr, rdv[7:0]}, {RESP_SLVERR, 8'h00});
		wr(12'h000, 8'h00);
		chk(br, RESP_SLVERR);
		for (i = 0; i < 400; i++) begin
			lf = nx(lf);
			d = lf[15:8];
			case (lf[3:0])
				4'h0: begin
					gs = gs + 3'h1;
					lv = lf[4];
					wr(IDX_GATE_WAKE_CTRL, {1'b0, lv, 1'b0, gs, 2'b00});
				end
				4'h1: begin
					p3s = d[3:0] & ~dir[7:4];
					wr(IDX_PT3_PIN_WAKE_SEL, {d[7:4], p3s});
				end
				4'h2: begin
					p2s = d;
					wr(IDX_P2_PIN_WAKE_SEL, d);
				end
				4'h3: begin
					dir = {d[7:4] & ~p3s, 4'h0};
					wr(IDX_PORT_DIR, dir);
				end
				4'h4: begin
					lat = d;
					rf = d[3:0];
					if (p3s != 4'h0) mode = REF_WRITE;
					wr(IDX_PORT3_DATA, d);
				end
				4'h5: begin
					rf = (dir[7:4] & lat[3:0]) | (~dir[7:4] & pn3);
					if (p3s != 4'h0) mode = REF_READ;
					rd(IDX_PORT3_DATA);
					chk(rdv[3:0], rf);
				end
				4'h6: begin
					en = d[0];
					mode = REF_NONE;
					wr(IDX_WAKE_STATUS, {3'h0, en, 4'h0});
				end
				4'h7: begin
					msk = d[2:0];
					wr(IDX_WAKE_MASK, {5'h0, msk});
				end
				4'h8: begin
					rd(IDX_WAKE_EVENTS);
					chk(rdv, {29'h0, stk});
					stk = ev();
				end
				default: begin
					pn3 = d[7:4];
					lf = nx(lf);
					{p0, p2} = lf;
					pv <= {p0, p2, pn3};
				end
			endcase
			repeat (10) @(posedge aclk);
			@(negedge aclk);
			e = ev();
			stk = stk | e;
			chk(wk, e[2]);
			chk(iq, e[2] & en);
			chk(wi, |(stk & msk));
			rd(IDX_WAKE_STATUS);
			chk(rdv, {27'h0, en, mode, 2'b00});
		end
		conclude();
	end
endmodule : swe_wake_logic_test
`default_nettype wire
